// >>> src/fcr_config_bank.sv
// Purpose: floppy logical-device configuration register bank
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: pins from outside pass two flip-flops before use

// Behaviour
// [RL1] Base address built from high byte at 0x60 and low byte at 0x61.
// [RL2] Unused base address registers ignore writes and read as zero.
// [RL3] Out-of-range base address makes decoded I/O accesses invalid and ignored.
// [RL4] Base address resets to 0x03/0xF0 on every reset including soft.
// [RL5] Vendor registers 0xE0-0xFE reset only on power-on or bus reset; here the reset input clears them as well.
// [RL6] Mode bit 0 selects normal or enhanced floppy mode.
// [RL7] Mode bit 1 selects burst DMA at 0, non-burst at 1.
// [RL8] Mode bits 3:2 select interface model; 11 default, 10 reserved.
// [RL9] Software always writes zero to mode bit 5.
// [RL10] Mode bit 6 selects open-drain or push-pull drive outputs.
// [RL11] Mode bit 7 tristates all drive outputs when set.
// [RL12] Option bit 0 forces write protect whenever a drive is selected.
// [RL13] Core write protect ORs soft bit, input, and qualified drive selects.
// [RL14] Option bits 3:2 choose normal, forced one or forced zero density.
// [RL15] Reserved option bits read zero and ignore writes.
module fcr_config_bank import fcr_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic mainPowerOnReset,
   input wire logic standbyPowerOnReset,
   input wire logic busReset,
   input wire logic softReset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regReadData,
   input wire logic [15:0] ioAddr,
   input wire logic ioStrobe,
   output logic ioAccessValid,
   input wire logic softWriteProtect,
   input wire logic writeProtectInput_n,
   input wire logic driveSelectZero_n,
   input wire logic driveSelectOne_n,
   input wire logic densityCore,
   output logic coreWriteProtect,
   output logic densityOut,
   output logic driveOutputEnable,
   output logic drivePushPull,
   output logic enhancedMode,
   output logic nonBurstDma,
   output logic [1:0] ifaceModel,
   output logic [15:0] baseAddress,
   output logic baseValid
);

   // ==========================================
   // Storage
   fcr_req_t req;
   fcr_cfg_t cfg;
   logic [7:0] baseHigh;
   logic [7:0] baseLow;
   logic [7:0] modeReg;
   logic [7:0] optionReg;
   logic fullReset;
   logic anyReset;
   logic [7:0] next_readData;
   logic [1:0] wpSync;
   logic [1:0] ds0Sync;
   logic [1:0] ds1Sync;
   logic [1:0] densSync;

   // Range and alignment test, shared by the valid flag and the access gate
   function automatic logic fcr_base_in_range(input logic [15:0] base);
      fcr_base_in_range = (base >= BASE_MIN) && (base <= BASE_MAX) && ((base & BASE_ALIGN_MASK) == 16'h0000);
   endfunction

   assign req = '{addr: regAddr, wdata: regWriteData, write: regWrite, read: regRead};

   // Vendor space keeps its contents through a soft reset
   assign fullReset = reset | mainPowerOnReset | standbyPowerOnReset | busReset; // [RL5]
   assign anyReset = fullReset | softReset; // [RL4]

   // ==========================================
   // Base address bytes
   always_ff @(posedge clk) begin
      if (anyReset) begin
         baseHigh <= RST_BASE_HIGH; // [RL4]
         baseLow <= RST_BASE_LOW; // [RL4]
      end else if (req.write) begin
         if (req.addr == IDX_BASE_HIGH) begin
            baseHigh <= req.wdata; // [RL1]
         end
         if (req.addr == IDX_BASE_LOW) begin
            baseLow <= req.wdata; // [RL1]
         end
      end
   end

   // ==========================================
   // Mode and option registers
   always_ff @(posedge clk) begin
      if (fullReset) begin
         modeReg <= RST_MODE; // [RL5]
         optionReg <= RST_OPTION; // [RL5]
      end else if (req.write) begin
         // Bit 5 is held at zero even if software slips
         if (req.addr == IDX_MODE) begin
            modeReg <= req.wdata & MODE_WRITE_MASK; // [RL9]
         end
         if (req.addr == IDX_OPTION) begin
            optionReg <= req.wdata & OPT_WRITE_MASK; // [RL15]
         end
      end
   end

   // ==========================================
   // Read port
   always_comb begin
      case (req.addr)
         IDX_BASE_HIGH: next_readData = baseHigh;
         IDX_BASE_LOW: next_readData = baseLow;
         IDX_BASE_SECOND_HIGH: next_readData = 8'h00; // [RL2]
         IDX_BASE_SECOND_LOW: next_readData = 8'h00; // [RL2]
         IDX_MODE: next_readData = modeReg;
         IDX_OPTION: next_readData = optionReg; // [RL15]
         default: next_readData = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         regReadData <= 8'h00;
      end else if (req.read) begin
         regReadData <= next_readData;
      end else begin
         regReadData <= 8'h00;
      end
   end

   // ==========================================
   // Decoded configuration
   always_comb begin
      cfg.enhancedMode = modeReg[MODE_ENHANCED_BIT]; // [RL6]
      cfg.nonBurstDma = modeReg[MODE_NON_BURST_BIT]; // [RL7]
      cfg.ifaceModel = fcr_iface_t'(modeReg[MODE_IFACE_LSB +: 2]); // [RL8]
      cfg.pushPull = modeReg[MODE_PUSH_PULL_BIT]; // [RL10]
      cfg.outputsTristate = modeReg[MODE_TRISTATE_BIT]; // [RL11]
      cfg.forceWriteProtect = optionReg[OPT_FORCE_WP_BIT]; // [RL12]
      cfg.densitySelect = fcr_density_t'(optionReg[OPT_DENSITY_LSB +: 2]); // [RL14]
      cfg.baseAddress = {baseHigh, baseLow}; // [RL1]
      cfg.baseValid = fcr_base_in_range({baseHigh, baseLow}); // [RL3]
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         enhancedMode <= RST_MODE[MODE_ENHANCED_BIT];
         nonBurstDma <= RST_MODE[MODE_NON_BURST_BIT];
         ifaceModel <= RST_MODE[MODE_IFACE_LSB +: 2];
         baseAddress <= {RST_BASE_HIGH, RST_BASE_LOW};
         // Held low for as long as reset is high; the reset base is judged once reset drops
         baseValid <= 1'h0;
      end else begin
         enhancedMode <= cfg.enhancedMode;
         nonBurstDma <= cfg.nonBurstDma;
         // Reserved model passes as written; the core treats it as standard
         ifaceModel <= cfg.ifaceModel;
         baseAddress <= cfg.baseAddress;
         baseValid <= cfg.baseValid;
      end
   end

   // ==========================================
   // I/O access gate: eight ports from the base up, only when base is legal
   always_ff @(posedge clk) begin
      if (reset) begin
         ioAccessValid <= 1'b0;
      end else begin
         ioAccessValid <= ioStrobe && cfg.baseValid
            && ((ioAddr & ~BASE_ALIGN_MASK) == cfg.baseAddress); // [RL3]
      end
   end

   // ==========================================
   // Pin synchronisers
   always_ff @(posedge clk) begin
      if (reset) begin
         wpSync <= 2'h3;
         ds0Sync <= 2'h3;
         ds1Sync <= 2'h3;
         densSync <= 2'h0;
      end else begin
         wpSync <= {wpSync[0], writeProtectInput_n};
         ds0Sync <= {ds0Sync[0], driveSelectZero_n};
         ds1Sync <= {ds1Sync[0], driveSelectOne_n};
         densSync <= {densSync[0], densityCore};
      end
   end

   fcr_drive_pins drivePins (
      .clk(clk),
      .reset(reset),
      .cfg(cfg),
      .softWriteProtect(softWriteProtect),
      .writeProtectInput_n(wpSync[1]),
      .driveSelectZero_n(ds0Sync[1]),
      .driveSelectOne_n(ds1Sync[1]),
      .densityCore(densSync[1]),
      .coreWriteProtect(coreWriteProtect),
      .densityOut(densityOut),
      .driveOutputEnable(driveOutputEnable),
      .drivePushPull(drivePushPull)
   );

endmodule

// >>> src/fcr_pkg.sv
// Purpose: constants and types for the floppy configuration register bank
// Assumes: 8-bit configuration index and data, one clock
// Notes: reset flavours arrive as single-cycle or level requests on clk
package fcr_pkg;

   // ==========================================
   // Register indices
   localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
   localparam logic [7:0] IDX_BASE_LOW = 8'h61;
   localparam logic [7:0] IDX_BASE_SECOND_HIGH = 8'h62;
   localparam logic [7:0] IDX_BASE_SECOND_LOW = 8'h63;
   localparam logic [7:0] IDX_MODE = 8'hF0;
   localparam logic [7:0] IDX_OPTION = 8'hF1;

   // ==========================================
   // Reset values
   localparam logic [7:0] RST_BASE_HIGH = 8'h03;
   localparam logic [7:0] RST_BASE_LOW = 8'hF0;
   localparam logic [7:0] RST_MODE = 8'h0E;
   localparam logic [7:0] RST_OPTION = 8'h00;

   // ==========================================
   // Field positions and masks
   localparam int MODE_ENHANCED_BIT = 0;
   localparam int MODE_NON_BURST_BIT = 1;
   localparam int MODE_IFACE_LSB = 2;
   localparam int MODE_PUSH_PULL_BIT = 6;
   localparam int MODE_TRISTATE_BIT = 7;
   localparam int OPT_FORCE_WP_BIT = 0;
   localparam int OPT_DENSITY_LSB = 2;
   localparam logic [7:0] MODE_WRITE_MASK = 8'hDF;
   localparam logic [7:0] OPT_WRITE_MASK = 8'h0D;

   // Base address window for this logical device, 8-byte aligned
   localparam logic [15:0] BASE_MIN = 16'h0100;
   localparam logic [15:0] BASE_MAX = 16'h0FF8;
   localparam logic [15:0] BASE_ALIGN_MASK = 16'h0007;

   // ==========================================
   // Types
   typedef enum logic [1:0] {
      IFACE_LEGACY_B = 2'h0,
      IFACE_LEGACY_A = 2'h1,
      IFACE_RESERVED = 2'h2,
      IFACE_STANDARD = 2'h3
   } fcr_iface_t;

   typedef enum logic [1:0] {
      DENS_NORMAL = 2'h0,
      DENS_NORMAL_USER = 2'h1,
      DENS_FORCE_ONE = 2'h2,
      DENS_FORCE_ZERO = 2'h3
   } fcr_density_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic write;
      logic read;
   } fcr_req_t;

   typedef struct packed {
      logic enhancedMode;
      logic nonBurstDma;
      fcr_iface_t ifaceModel;
      logic pushPull;
      logic outputsTristate;
      logic forceWriteProtect;
      fcr_density_t densitySelect;
      logic [15:0] baseAddress;
      logic baseValid;
   } fcr_cfg_t;

endpackage

// >>> src/fcr_drive_pins.sv
// Purpose: drive-side pin qualification from configuration
// Assumes: inputs already synchronised to clk; drive selects active low
// Notes: outputs registered
module fcr_drive_pins import fcr_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input fcr_cfg_t cfg,
   input wire logic softWriteProtect,
   input wire logic writeProtectInput_n,
   input wire logic driveSelectZero_n,
   input wire logic driveSelectOne_n,
   input wire logic densityCore,
   output logic coreWriteProtect,
   output logic densityOut,
   output logic driveOutputEnable,
   output logic drivePushPull
);

   // ==========================================
   // Write protect towards the core
   always_ff @(posedge clk) begin
      if (reset) begin
         coreWriteProtect <= 1'h0;
      end else begin
         coreWriteProtect <= softWriteProtect | ~writeProtectInput_n
            | (~driveSelectZero_n & cfg.forceWriteProtect)
            | (~driveSelectOne_n & cfg.forceWriteProtect); // [RL12] [RL13]
      end
   end

   // ==========================================
   // Density output override
   always_ff @(posedge clk) begin
      if (reset) begin
         densityOut <= 1'h0;
      end else begin
         case (cfg.densitySelect) // [RL14]
            DENS_FORCE_ONE: densityOut <= 1'h1;
            DENS_FORCE_ZERO: densityOut <= 1'h0;
            default: densityOut <= densityCore;
         endcase
      end
   end

   // ==========================================
   // Output driver style
   always_ff @(posedge clk) begin
      if (reset) begin
         driveOutputEnable <= 1'h0;
         drivePushPull <= 1'h0;
      end else begin
         driveOutputEnable <= ~cfg.outputsTristate; // [RL11]
         drivePushPull <= cfg.pushPull; // [RL10]
      end
   end

endmodule

// >>> verif/fcr_config_bank_sva.sv
// Purpose: port assertions for the floppy configuration bank
// Assumes: one clock, synchronous active-high reset
// Notes: config outputs lag a register change by one edge
module fcr_config_bank_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic mainPowerOnReset,
   input wire logic standbyPowerOnReset,
   input wire logic busReset,
   input wire logic softReset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic ioStrobe,
   input wire logic ioAccessValid,
   input wire logic enhancedMode,
   input wire logic nonBurstDma,
   input wire logic [1:0] ifaceModel,
   input wire logic drivePushPull,
   input wire logic driveOutputEnable,
   input wire logic [15:0] baseAddress,
   input wire logic baseValid
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   logic hardRst;
   logic baseRst;
   assign hardRst = mainPowerOnReset | standbyPowerOnReset | busReset;
   assign baseRst = hardRst | softReset;
   // ==========================================
   // Write sequences, no reset that clears the written register may cut in
   sequence s_mode_wr;
      regWrite && regAddr == 8'hF0 && !hardRst ##1 !hardRst;
   endsequence
   sequence s_high_wr;
      regWrite && regAddr == 8'h60 && !baseRst ##1 !baseRst;
   endsequence
   // ==========================================
   // Assertions
   a_mode_enhanced: assert property (s_mode_wr |=> enhancedMode == $past(regWriteData[0], 2))
      else $error("enhanced mode wrong");
   a_mode_burst: assert property (s_mode_wr |=> nonBurstDma == $past(regWriteData[1], 2))
      else $error("dma mode wrong");
   a_mode_iface: assert property (s_mode_wr |=> ifaceModel == $past(regWriteData[3:2], 2))
      else $error("interface model wrong");
   a_drive_type: assert property (s_mode_wr |=> drivePushPull == $past(regWriteData[6], 2))
      else $error("output type wrong");
   a_drive_tristate: assert property (s_mode_wr |=> driveOutputEnable != $past(regWriteData[7], 2))
      else $error("output enable wrong");
   a_base_high: assert property (s_high_wr |=> baseAddress[15:8] == $past(regWriteData, 2))
      else $error("base high byte wrong");
   a_soft_base: assert property (softReset |-> ##2 baseAddress == 16'h03F0)
      else $error("base not reset by soft reset");
   a_unused_zero: assert property (regRead && regAddr[7:1] == 7'h31 |=> regReadData == 8'h00)
      else $error("unused base register not zero");
   a_opt_reserved: assert property (regRead && regAddr == 8'hF1 |=> (regReadData & 8'hF2) == 8'h00)
      else $error("reserved option bits set");
   // The valid flag lags the base by one edge and is forced low in reset, so skip those edges
   a_io_invalid: assert property (ioStrobe && !baseValid && !$past(regWrite)
      && !$past(baseRst) && !$past(reset) |=> !ioAccessValid)
      else $error("access accepted with invalid base");
endmodule

bind fcr_config_bank fcr_config_bank_sva u_sva (.clk, .reset, .mainPowerOnReset, .standbyPowerOnReset,
   .busReset, .softReset, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .ioStrobe,
   .ioAccessValid, .enhancedMode, .nonBurstDma, .ifaceModel, .drivePushPull, .driveOutputEnable,
   .baseAddress, .baseValid);

// >>> verif/fcr_config_bank_tb.sv
// Purpose: self-checking bench for the floppy configuration bank
// Assumes: register read data one cycle after the read strobe
// Notes: pin outputs given four edges to pass the synchroniser
module fcr_config_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, mainPowerOnReset, standbyPowerOnReset, busReset, softReset;
   logic [7:0] regAddr, regWriteData, regReadData;
   logic regWrite, regRead, ioStrobe, ioAccessValid, softWriteProtect;
   logic writeProtectInput_n, driveSelectZero_n, driveSelectOne_n, densityCore;
   logic coreWriteProtect, densityOut, driveOutputEnable, drivePushPull;
   logic enhancedMode, nonBurstDma, baseValid;
   logic [1:0] ifaceModel;
   logic [15:0] ioAddr, baseAddress;
   int fails = 0;
   int total_checks = 0;

   fcr_config_bank u_dut (.clk, .reset, .mainPowerOnReset, .standbyPowerOnReset, .busReset,
      .softReset, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .ioAddr, .ioStrobe,
      .ioAccessValid, .softWriteProtect, .writeProtectInput_n, .driveSelectZero_n,
      .driveSelectOne_n, .densityCore, .coreWriteProtect, .densityOut, .driveOutputEnable,
      .drivePushPull, .enhancedMode, .nonBurstDma, .ifaceModel, .baseAddress, .baseValid);

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // ==========================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks=%0d fails=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'h1;
      @(posedge clk);
      regWrite <= 1'h0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'h1;
      @(posedge clk);
      regRead <= 1'h0;
      #1;
      check(regReadData, e);
   endtask

   task automatic io(input logic [15:0] a, input logic e);
      @(posedge clk);
      ioAddr <= a;
      ioStrobe <= 1'h1;
      @(posedge clk);
      ioStrobe <= 1'h0;
      #1;
      check(ioAccessValid, e);
   endtask

   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset;
      settle;
      check(baseAddress, 16'h03F0);
      check(baseValid, 1'h1);
      check({enhancedMode, nonBurstDma, ifaceModel}, 4'h7);
      check({drivePushPull, driveOutputEnable}, 2'h1);
      rdchk(8'hF0, 8'h0E);
      rdchk(8'hF1, 8'h00);
      $display("reset values done");
   endtask

   task automatic t_base;
      wr(8'h60, 8'h02);
      wr(8'h61, 8'hF8);
      wr(8'h62, 8'hA5);
      rdchk(8'h62, 8'h00);
      rdchk(8'h63, 8'h00);
      rdchk(8'h61, 8'hF8);
      settle;
      check(baseAddress, 16'h02F8);
      io(16'h02FF, 1'h1);
      io(16'h0300, 1'h0);
      // Base 0x00F8 lies below the legal window
      wr(8'h60, 8'h00);
      settle;
      check(baseValid, 1'h0);
      io(16'h00F8, 1'h0);
      $display("base address done");
   endtask

   task automatic t_mode;
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         d = {i[1], i[0], 2'h0, i[1:0], ~i[0], i[1]};
         wr(8'hF0, d);
         rdchk(8'hF0, d);
         settle;
         check({enhancedMode, nonBurstDma, ifaceModel}, {d[0], d[1], d[3:2]});
         check({drivePushPull, driveOutputEnable}, {d[6], ~d[7]});
      end
      $display("mode register done");
   endtask

   task automatic t_option;
      wr(8'hF1, 8'hF2);
      rdchk(8'hF1, 8'h00);
      for (int i = 0; i < 32; i++) begin
         wr(8'hF1, {4'h0, i[3:2], 1'h0, i[4]});
         softWriteProtect <= i[0];
         writeProtectInput_n <= i[1];
         driveSelectZero_n <= i[2];
         driveSelectOne_n <= i[3];
         densityCore <= i[1];
         rdchk(8'hF1, {4'h0, i[3:2], 1'h0, i[4]});
         settle;
         // Braces keep each expected bit one wide, else the inversions fill all sixteen bits
         check(coreWriteProtect, {i[0] | ~i[1] | (i[4] & ~(i[2] & i[3]))});
         check(densityOut, {i[3] ? ~i[2] : i[1]});
      end
      $display("option register done");
   endtask

   task automatic t_resets;
      wr(8'hF0, 8'h41);
      wr(8'h61, 8'h00);
      @(posedge clk);
      softReset <= 1'h1;
      @(posedge clk);
      softReset <= 1'h0;
      rdchk(8'h61, 8'hF0);
      rdchk(8'h60, 8'h03);
      rdchk(8'hF0, 8'h41);
      for (int k = 0; k < 3; k++) begin
         wr(8'hF1, 8'h0C);
         wr(8'h60, 8'h05);
         @(posedge clk);
         {mainPowerOnReset, standbyPowerOnReset, busReset} <= 3'h4 >> k;
         @(posedge clk);
         {mainPowerOnReset, standbyPowerOnReset, busReset} <= 3'h0;
         rdchk(8'hF1, 8'h00);
         rdchk(8'h60, 8'h03);
      end
      rdchk(8'hF0, 8'h0E);
      $display("reset kinds done");
   endtask

   initial begin
      reset = 1'h1;
      {mainPowerOnReset, standbyPowerOnReset, busReset, softReset} = 4'h0;
      {regWrite, regRead, ioStrobe, softWriteProtect, densityCore} = 5'h00;
      {writeProtectInput_n, driveSelectZero_n, driveSelectOne_n} = 3'h7;
      regAddr = 8'h00;
      regWriteData = 8'h00;
      ioAddr = 16'h0000;
      repeat (8) @(posedge clk);
      reset <= 1'h0;
      t_reset;
      t_base;
      t_mode;
      t_option;
      t_resets;
      end_of_test;
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_of_test;
   end
endmodule
